// >>> hdl/sbmc_controller.sv
`timescale 1ns/1ps
module sbmc_controller
    import sbmc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // cpu side
    input wire logic i_command_request_in,
    input wire logic i_request_strobe_n,
    input wire logic i_cpu_mem_read_n,
    input wire logic i_cpu_mem_write_n,
    input wire logic i_cpu_port_read_n,
    input wire logic i_cpu_port_write_n,
    input wire logic [SBMC_ADDR_W-1:0] i_cpu_addr,
    input wire logic [SBMC_DATA_W-1:0] i_cpu_wdata,
    input wire logic [3:0] i_delay_adjust,
    output logic o_cpu_ready,
    output logic [SBMC_DATA_W-1:0] o_cpu_rdata,
    // shared bus side
    input wire logic i_bus_clk_n,
    input wire logic i_priority_chain_in_n,
    input wire logic i_transfer_ack_n,
    input wire logic i_advance_ack_n,
    input wire logic i_busy_n,
    input wire logic [SBMC_DATA_W-1:0] i_bus_data,
    output logic o_bus_request_n,
    output logic o_priority_chain_out_n,
    output logic o_busy_n,
    output logic o_busy_oe_n,
    output logic o_addr_data_drive_en_n,
    output logic o_bus_mem_read_cmd_n,
    output logic o_bus_mem_write_cmd_n,
    output logic o_bus_port_read_cmd_n,
    output logic o_bus_port_write_cmd_n,
    output logic [SBMC_ADDR_W-1:0] o_bus_addr,
    output logic [SBMC_DATA_W-1:0] o_bus_data,
    output logic o_bus_data_oe_n
);
    // pin synchronisers; first stage read only by second
    logic bclk_s1_reg, bclk_s1_next;
    logic prn_s1_reg, prn_s1_next;
    logic [1:0] ack_s1_reg, ack_s1_next;
    logic busy_s1_reg, busy_s1_next;
    logic [SBMC_DATA_W-1:0] data_s1_reg, data_s1_next;
    logic bclk_s2_reg, bclk_s2_next;
    logic bclk_old_reg, bclk_old_next;
    logic prn_s2_reg, prn_s2_next;
    logic [1:0] ack_s2_reg, ack_s2_next;
    logic busy_s2_reg, busy_s2_next;
    logic [SBMC_DATA_W-1:0] data_s2_reg, data_s2_next;

    always_comb begin
        bclk_s1_next = i_bus_clk_n;
        prn_s1_next = i_priority_chain_in_n;
        // acks kept apart until synced; gating raw pins could glitch
        ack_s1_next = {i_advance_ack_n, i_transfer_ack_n};
        busy_s1_next = i_busy_n;
        // data holds while ack is low and is only taken then
        data_s1_next = i_bus_data;
        bclk_s2_next = bclk_s1_reg;
        bclk_old_next = bclk_s2_reg;
        prn_s2_next = prn_s1_reg;
        ack_s2_next = ack_s1_reg;
        busy_s2_next = busy_s1_reg;
        data_s2_next = data_s1_reg;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            bclk_s1_reg <= 1'b1;
            prn_s1_reg <= 1'b1;
            ack_s1_reg <= 2'h3;
            busy_s1_reg <= 1'b1;
            data_s1_reg <= '0;
            bclk_s2_reg <= 1'b1;
            bclk_old_reg <= 1'b1;
            prn_s2_reg <= 1'b1;
            ack_s2_reg <= 2'h3;
            busy_s2_reg <= 1'b1;
            data_s2_reg <= '0;
        end else begin
            bclk_s1_reg <= bclk_s1_next;
            prn_s1_reg <= prn_s1_next;
            ack_s1_reg <= ack_s1_next;
            busy_s1_reg <= busy_s1_next;
            data_s1_reg <= data_s1_next;
            bclk_s2_reg <= bclk_s2_next;
            bclk_old_reg <= bclk_old_next;
            prn_s2_reg <= prn_s2_next;
            ack_s2_reg <= ack_s2_next;
            busy_s2_reg <= busy_s2_next;
            data_s2_reg <= data_s2_next;
        end
    end

    logic bclk_rise, bclk_fall;
    assign bclk_rise = bclk_s2_reg & ~bclk_old_reg;
    assign bclk_fall = ~bclk_s2_reg & bclk_old_reg;

    sbmc_state_t state_reg, state_next;
    logic [3:0] kind_reg, kind_next;
    logic [3:0] delay_reg, delay_next;
    logic [SBMC_ADDR_W-1:0] addr_reg, addr_next;
    logic [SBMC_DATA_W-1:0] wdata_reg, wdata_next;
    logic [SBMC_DATA_W-1:0] rdata_reg, rdata_next;
    logic ready_reg, ready_next;
    logic bus_request_n_reg, bus_request_n_next;
    logic priority_chain_out_n_reg, priority_chain_out_n_next;
    logic busy_reg, busy_next;
    logic addr_data_drive_en_n_reg, addr_data_drive_en_n_next;
    logic [3:0] cmd_reg, cmd_next;
    logic data_oe_n_reg, data_oe_n_next;
    logic is_write;

    // kind bits: mem read, mem write, port read, port write
    assign is_write = kind_reg[1] | kind_reg[3];

    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        delay_next = delay_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        ready_next = 1'b0;
        bus_request_n_next = bus_request_n_reg;
        priority_chain_out_n_next = priority_chain_out_n_reg;
        busy_next = busy_reg;
        addr_data_drive_en_n_next = addr_data_drive_en_n_reg;
        cmd_next = cmd_reg;
        data_oe_n_next = data_oe_n_reg;
        unique case (state_reg)
            SBMC_IDLE: begin
                // strobe is held enabled on board; low level captures
                if (i_command_request_in && !i_request_strobe_n) begin
                    kind_next = ~{i_cpu_port_write_n, i_cpu_port_read_n,
                                  i_cpu_mem_write_n, i_cpu_mem_read_n};
                    addr_next = i_cpu_addr;
                    wdata_next = i_cpu_wdata;
                    state_next = SBMC_WAIT_RISE;
                end
            end
            SBMC_WAIT_RISE: begin
                if (bclk_rise) begin
                    state_next = SBMC_WAIT_FALL;
                end
            end
            SBMC_WAIT_FALL: begin
                if (bclk_fall) begin
                    bus_request_n_next = 1'b0;
                    priority_chain_out_n_next = 1'b1;
                    state_next = SBMC_REQUEST;
                end
            end
            SBMC_REQUEST: begin
                // grant sampled on falling edge; wait for bus not busy
                if (bclk_fall && !prn_s2_reg && busy_s2_reg) begin
                    busy_next = 1'b0;
                    addr_data_drive_en_n_next = 1'b0;
                    data_oe_n_next = ~is_write;
                    delay_next = (i_delay_adjust == SBMC_DELAY_RESET) ? SBMC_CMD_DELAY : i_delay_adjust;
                    state_next = SBMC_SETUP;
                end
            end
            SBMC_SETUP: begin
                // counted in bus clocks to give address setup margin
                if (bclk_fall) begin
                    if (delay_reg == 4'h1) begin
                        cmd_next = ~kind_reg;
                        state_next = SBMC_COMMAND;
                    end else begin
                        delay_next = delay_reg - 4'h1;
                    end
                end
            end
            SBMC_COMMAND: begin
                if (ack_s2_reg != 2'h3) begin
                    rdata_next = data_s2_reg;
                    ready_next = 1'b1;
                    cmd_next = 4'hF;
                    addr_data_drive_en_n_next = 1'b1;
                    data_oe_n_next = 1'b1;
                    busy_next = 1'b1;
                    bus_request_n_next = 1'b1;
                    priority_chain_out_n_next = 1'b0;
                    state_next = SBMC_IDLE;
                end
            end
            default: state_next = SBMC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_reg <= SBMC_IDLE;
            kind_reg <= 4'h0;
            delay_reg <= SBMC_DELAY_RESET;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            ready_reg <= 1'b0;
            bus_request_n_reg <= 1'b1;
            priority_chain_out_n_reg <= 1'b0;
            busy_reg <= 1'b1;
            addr_data_drive_en_n_reg <= 1'b1;
            cmd_reg <= 4'hF;
            data_oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            delay_reg <= delay_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            bus_request_n_reg <= bus_request_n_next;
            priority_chain_out_n_reg <= priority_chain_out_n_next;
            busy_reg <= busy_next;
            addr_data_drive_en_n_reg <= addr_data_drive_en_n_next;
            cmd_reg <= cmd_next;
            data_oe_n_reg <= data_oe_n_next;
        end
    end

    assign o_cpu_ready = ready_reg;
    assign o_cpu_rdata = rdata_reg;
    assign o_bus_request_n = bus_request_n_reg;
    assign o_priority_chain_out_n = priority_chain_out_n_reg;
    assign o_busy_n = busy_reg;
    assign o_busy_oe_n = busy_reg;
    assign o_addr_data_drive_en_n = addr_data_drive_en_n_reg;
    assign o_bus_mem_read_cmd_n = cmd_reg[0];
    assign o_bus_mem_write_cmd_n = cmd_reg[1];
    assign o_bus_port_read_cmd_n = cmd_reg[2];
    assign o_bus_port_write_cmd_n = cmd_reg[3];
    assign o_bus_addr = addr_reg;
    assign o_bus_data = wdata_reg;
    assign o_bus_data_oe_n = data_oe_n_reg;
endmodule : sbmc_controller

// >>> hdl/sbmc_pkg.sv
// Overview of operation
// - arbitrate on bus clock falling edges
// - start only on captured command request
// - rise then fall, then request and block chain
// - chain out high while wanting bus
// - grant asserts busy and drive enable low
// - hold busy until transfer completes
// - drive enable opens address and data drivers
// - issue command matching cpu request kind
// - drive address, gate data by direction
// - slave acknowledge returned as cpu ready
package sbmc_pkg;
    localparam int SBMC_ADDR_W = 20;
    localparam int SBMC_DATA_W = 8;
    localparam logic [3:0] SBMC_CMD_DELAY = 4'h2;
    localparam logic [3:0] SBMC_DELAY_RESET = 4'h0;

    typedef enum logic [5:0] {
        SBMC_IDLE = 6'h01,
        SBMC_WAIT_RISE = 6'h02,
        SBMC_WAIT_FALL = 6'h04,
        SBMC_REQUEST = 6'h08,
        SBMC_SETUP = 6'h10,
        SBMC_COMMAND = 6'h20
    } sbmc_state_t;
endpackage : sbmc_pkg

// >>> sim/sbmc_checker.sv
`timescale 1ns/1ps
module sbmc_checker (
    input wire logic i_clk, i_reset_n, o_cpu_ready, o_bus_request_n, o_priority_chain_out_n, o_busy_n,
    input wire logic o_busy_oe_n, o_addr_data_drive_en_n, o_bus_data_oe_n, o_bus_mem_read_cmd_n,
    input wire logic o_bus_mem_write_cmd_n, o_bus_port_read_cmd_n, o_bus_port_write_cmd_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic [3:0] c;
    assign c = {o_bus_port_write_cmd_n, o_bus_port_read_cmd_n, o_bus_mem_write_cmd_n, o_bus_mem_read_cmd_n};
    chain_block_a: assert property (o_bus_request_n == !o_priority_chain_out_n)
        else $error("chain out vs request");
    busy_enable_a: assert property (o_busy_n == o_addr_data_drive_en_n && o_busy_oe_n == o_busy_n)
        else $error("busy and enable split");
    grant_req_a: assert property ($fell(o_busy_n) |-> !o_bus_request_n)
        else $error("busy without request");
    busy_hold_a: assert property ($rose(o_busy_n) |-> o_cpu_ready)
        else $error("busy dropped early");
    cmd_owner_a: assert property (c != 4'hF |-> !o_busy_n && !o_addr_data_drive_en_n)
        else $error("command without bus");
    one_cmd_a: assert property ($onehot0(~c))
        else $error("two commands");
    data_dir_a: assert property (c != 4'hF |-> o_bus_data_oe_n == (c[1] && c[3]))
        else $error("data drive direction");
    cmd_ready_a: assert property ($rose(&c) |-> o_cpu_ready)
        else $error("command end without ready");
    ready_pulse_a: assert property (o_cpu_ready |=> !o_cpu_ready)
        else $error("ready too long");
    cover property ($fell(o_busy_n));
    cover property (!o_bus_port_write_cmd_n);
    cover property (o_cpu_ready);
endmodule : sbmc_checker

// >>> sim/sbmc_partner.sv
`timescale 1ns/1ps
module sbmc_partner #(parameter logic [7:0] RD = 8'h3C) (
    input wire logic i_req_n, i_busy_oe_n, i_cmd_n, i_adv,
    input wire logic [3:0] i_wait,
    output logic o_clk_n, o_grant_n, o_transfer_ack_n_n, o_advance_ack_n_n, o_busy_n,
    output logic [7:0] o_data
);
    initial begin
        o_clk_n = 1;
        forever #400 o_clk_n = ~o_clk_n;
    end
    // lone resolver, no lower master behind us
    initial begin
        o_grant_n = 1;
        forever @(negedge o_clk_n) o_grant_n <= i_req_n;
    end
    // busy wire pulled up unless the board pulls it low
    assign o_busy_n = i_busy_oe_n;
    // bus floats to inverse when no slave answers
    assign o_data = (o_transfer_ack_n_n & o_advance_ack_n_n) ? ~RD : RD;
    // answers land mid-cycle, away from the sampling edge
    initial begin
        o_transfer_ack_n_n = 1;
        o_advance_ack_n_n = 1;
        forever begin
            @(negedge i_cmd_n);
            #(i_wait * 100 + 50);
            if (i_adv) o_advance_ack_n_n = 0;
            else o_transfer_ack_n_n = 0;
            @(posedge i_cmd_n);
            #50;
            o_transfer_ack_n_n = 1;
            o_advance_ack_n_n = 1;
        end
    end
endmodule : sbmc_partner

// >>> sim/sbmc_controller_tb_top.sv
`timescale 1ns/1ps
module sbmc_controller_tb_top;
    import sbmc_pkg::*;
    logic i_clk, i_reset_n, i_command_request_in, i_request_strobe_n, i_cpu_mem_read_n, i_cpu_mem_write_n;
    logic i_cpu_port_read_n, i_cpu_port_write_n, i_bus_clk_n, i_priority_chain_in_n, i_transfer_ack_n;
    logic i_advance_ack_n, i_busy_n, o_cpu_ready, o_bus_request_n, o_priority_chain_out_n, o_busy_n;
    logic o_busy_oe_n, o_addr_data_drive_en_n, o_bus_data_oe_n, o_bus_mem_read_cmd_n, o_bus_mem_write_cmd_n;
    logic o_bus_port_read_cmd_n, o_bus_port_write_cmd_n, adv;
    logic [SBMC_ADDR_W-1:0] i_cpu_addr, o_bus_addr;
    logic [SBMC_DATA_W-1:0] i_cpu_wdata, o_cpu_rdata, i_bus_data, o_bus_data;
    logic [3:0] i_delay_adjust, cmd_n, wt, want;
    int n_fail, checks_done, cyc, n;
    typedef struct {logic [1:0] k; logic [3:0] d, w; logic a;} sbmc_row_t;
    sbmc_row_t rows[4] = '{'{2'h0, 4'h0, 4'h0, 1'b0}, '{2'h1, 4'h1, 4'h3, 1'b1},
        '{2'h2, 4'h3, 4'h0, 1'b1}, '{2'h3, 4'h5, 4'h7, 1'b0}};
    assign cmd_n = {o_bus_port_write_cmd_n, o_bus_port_read_cmd_n, o_bus_mem_write_cmd_n, o_bus_mem_read_cmd_n};
    sbmc_controller uut (.*);
    sbmc_partner #(.RD(8'h3C)) far (.i_req_n(o_bus_request_n), .i_busy_oe_n(o_busy_oe_n), .i_cmd_n(&cmd_n),
        .i_adv(adv), .i_wait(wt), .o_clk_n(i_bus_clk_n), .o_grant_n(i_priority_chain_in_n),
        .o_transfer_ack_n_n(i_transfer_ack_n), .o_advance_ack_n_n(i_advance_ack_n), .o_busy_n(i_busy_n), .o_data(i_bus_data));
    task automatic chk(input string nm, input logic [19:0] e, g);
        checks_done++;
        if (e !== g) begin
            n_fail++;
            $display("[ERR] %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task automatic chk_idle(input string nm);
        chk(nm, 20'h2FE, {o_bus_request_n, o_priority_chain_out_n, o_busy_n, o_addr_data_drive_en_n, cmd_n,
            o_bus_data_oe_n, o_cpu_ready});
    endtask : chk_idle
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask : step
    task automatic tally_and_finish();
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // one-edge request pulse avoids a second capture at ready
    task automatic start(input logic [1:0] k, input logic [3:0] d);
        i_command_request_in = 1;
        {i_cpu_port_write_n, i_cpu_port_read_n, i_cpu_mem_write_n, i_cpu_mem_read_n} = ~(4'h1 << k);
        i_delay_adjust = d;
        i_cpu_addr = {16'hC0DE, 2'h0, k};
        i_cpu_wdata = {6'h15, k};
        step();
        i_command_request_in = 0;
    endtask : start
    initial begin
        i_clk = 0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        {i_reset_n, i_command_request_in, i_request_strobe_n, adv, wt} = '0;
        {i_cpu_port_write_n, i_cpu_port_read_n, i_cpu_mem_write_n, i_cpu_mem_read_n} = 4'hF;
        {i_delay_adjust, i_cpu_addr, i_cpu_wdata} = '0;
        repeat (3) step();
        i_reset_n = 1;
        repeat (3) begin
            step();
            chk_idle("rst");
        end
        foreach (rows[r]) begin
            wt = rows[r].w;
            adv = rows[r].a;
            want = ~(4'h1 << rows[r].k);
            start(rows[r].k, rows[r].d);
            for (n = 0; n < 300 && o_addr_data_drive_en_n; n++) step();
            chk("chain", 1'b1, o_priority_chain_out_n);
            chk("busy", 2'h0, {o_busy_n, o_busy_oe_n});
            for (n = 0; n < 300 && &cmd_n; n++) step();
            chk("delay", 20'((rows[r].d == 4'h0 ? SBMC_CMD_DELAY : rows[r].d) * 8), 20'(n));
            chk("cmd", want, cmd_n);
            chk("addr", i_cpu_addr, o_bus_addr);
            chk("oe", !rows[r].k[0], o_bus_data_oe_n);
            if (rows[r].k[0]) chk("wdata", i_cpu_wdata, o_bus_data);
            for (n = 0; n < 300 && !o_cpu_ready; n++) step();
            chk("ready", 1'b1, o_cpu_ready);
            if (!rows[r].k[0]) chk("rdata", 8'h3C, o_cpu_rdata);
            step();
        end
        i_request_strobe_n = 1;
        start(2'h0, 4'h0);
        repeat (40) step();
        chk("nostrobe", 1'b1, o_bus_request_n);
        i_request_strobe_n = 0;
        start(2'h1, 4'h5);
        for (n = 0; n < 300 && o_busy_n; n++) step();
        i_reset_n = 0;
        repeat (3) step();
        chk_idle("midrst");
        i_reset_n = 1;
        repeat (3) begin
            step();
            chk_idle("rst2");
        end
        start(2'h2, 4'h1);
        for (n = 0; n < 300 && !o_cpu_ready; n++) step();
        chk("ready2", 1'b1, o_cpu_ready);
        chk("rdata2", 8'h3C, o_cpu_rdata);
        tally_and_finish();
    end
endmodule : sbmc_controller_tb_top
bind sbmc_controller sbmc_checker chk (.*);
